//--- design/tap_cfg.svh
// Register offsets, protection masks, reset values and timing counts
// Functional notes
// - Key AAh then 55h at C7h arms
// - Window stays open three machine cycles
// - Protect port 4/6 bits 5-0, port 5 bits 2-0
// - Protect address control bits 5 to 0
// - Protect watchdog bits 6, 3, 1, 0
// - Protect CAN reset and clock-output fields
// - Protect memory control chip-enable, write-protect bits
// - Protect buffer flush, size and bandgap select
// - Mode 00 16-bit, 01 paged, 1x contiguous
// - Mode resets contiguous with ROM, else 16-bit
// - 16-bit mode limits memory to 64 kB
// - Special bits reset only on certain sources
`ifndef TAP_CFG_SVH
`define TAP_CFG_SVH
`define ADDR_EXT_INTERRUPT_FLAGS     8'h91
`define ADDR_P4       8'h92
`define ADDR_ADDRESS_CONTROL     8'h9d
`define ADDR_P5       8'ha2
`define ADDR_CAN      8'ha3
`define ADDR_P6       8'hb2
`define ADDR_MEMORY_CHIP_ENABLE_CTRL     8'hc6
`define ADDR_KEY      8'hc7
`define ADDR_COR      8'hce
`define ADDR_UPPER_CHIP_ENABLE_CTRL    8'hd6
`define ADDR_WRITE_PROTECT_CTRL    8'hd7
`define ADDR_WATCHDOG_CONTROL    8'hd8
`define ADDR_EBS      8'he5
`define KEY_FIRST     8'haa
`define KEY_SECOND    8'h55
`define MASK_EXT_INTERRUPT_FLAGS     8'h01
`define MASK_P4       8'h3f
`define MASK_ADDRESS_CONTROL     8'h3f
`define MASK_P5       8'h07
`define MASK_CAN      8'h08
`define MASK_P6       8'h3f
`define MASK_MEMORY_CHIP_ENABLE_CTRL     8'h2f
`define MASK_COR      8'h9f
`define MASK_UPPER_CHIP_ENABLE_CTRL    8'h0f
`define MASK_WRITE_PROTECT_CTRL    8'h7f
`define MASK_WATCHDOG_CONTROL    8'h4b
`define MASK_EBS      8'h9f
`define SPECIAL_EXT_INTERRUPT_FLAGS  8'h0e
`define SPECIAL_ADDRESS_CONTROL  8'h08
`define SPECIAL_WATCHDOG_CONTROL 8'h54
`define RST_EXT_INTERRUPT_FLAGS      8'h00
`define RST_P4        8'hff
`define RST_ADDRESS_CONTROL      8'hc0
`define RST_P5        8'h80
`define RST_CAN       8'h09
`define RST_P6        8'h00
`define RST_MEMORY_CHIP_ENABLE_CTRL      8'hf0
`define RST_COR       8'h60
`define RST_UPPER_CHIP_ENABLE_CTRL     8'h30
`define RST_WRITE_PROTECT_CTRL     8'h00
`define RST_WATCHDOG_CONTROL     8'h00
`define RST_EBS       8'h60
`define MODE_CONTIG   2'b10
`define MODE_16BIT    2'b00
`define WINDOW_CYCLES 2'd3
`define MEM_16BIT_LIMIT 24'h00ffff
`endif

//--- design/tap_pkg.sv
// Types shared by the protection unit
package tap_pkg;
    typedef enum logic [1:0] {
        mode_16bit,
        mode_paged,
        mode_contiguous
    } address_mode_type;
    typedef enum logic [1:0] {
        key_idle,
        key_half,
        key_open
    } key_state_type;
endpackage

//--- design/tap_window.sv
// Unlock key sequencer and access window timer
`timescale 1ns/10ps
`include "tap_cfg.svh"
module tap_window (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       cycle_tick,
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_addr,
    input  wire logic [7:0] wr_data,
    output tap_pkg::key_state_type state,
    output logic            window_open
);
    import tap_pkg::*;
    logic [1:0] remaining;
    logic       key_write;
    logic       other_write;

    assign key_write   = wr_en && (wr_addr == `ADDR_KEY);
    assign other_write = wr_en && (wr_addr != `ADDR_KEY);
    assign window_open = (state == key_open);

    always_ff @(posedge clk) begin
        if (reset) begin
            state     <= key_idle;
            remaining <= 2'd0;
        end else begin
            case (state)
                key_idle: begin
                    if (key_write && wr_data == `KEY_FIRST) begin
                        state <= key_half;
                    end
                end
                key_half: begin
                    if (key_write && wr_data == `KEY_SECOND) begin
                        state     <= key_open;
                        remaining <= `WINDOW_CYCLES;
                    end else if (key_write && wr_data == `KEY_FIRST) begin
                        state <= key_half;
                    end else if (wr_en) begin
                        state <= key_idle;
                    end
                end
                key_open: begin
                    // One write to any non-key address consumes the window
                    if (other_write) begin
                        state <= key_idle;
                    end else if (key_write) begin
                        state <= (wr_data == `KEY_FIRST) ? key_half : key_idle;
                    end else if (cycle_tick) begin
                        if (remaining == 2'd1) begin
                            state <= key_idle;
                        end
                        remaining <= remaining - 2'd1;
                    end
                end
                default: state <= key_idle;
            endcase
        end
    end
endmodule

//--- design/timed_access_protection.sv
// Register bank guarded by the timed-access unlock window
`timescale 1ns/10ps
`include "tap_cfg.svh"
module timed_access_protection #(
    parameter int CYCLE_DIV = 4
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        power_on_reset,
    input  wire logic        rom_enabled,
    input  wire logic        wr_en,
    input  wire logic [7:0]  wr_addr,
    input  wire logic [7:0]  wr_data,
    input  wire logic        rd_en,
    input  wire logic [7:0]  rd_addr,
    input  wire logic [23:0] mem_addr,
    output logic [7:0]       rd_data,
    output logic             rd_hit,
    output logic             window_open,
    output logic [7:0]       ext_interrupt_flags,
    output logic [7:0]       port4_pin_config,
    output logic [7:0]       address_control,
    output logic [7:0]       port5_pin_config,
    output logic [7:0]       can0_control,
    output logic [7:0]       port6_pin_config,
    output logic [7:0]       memory_chip_enable_ctrl,
    output logic [7:0]       clock_output_config,
    output logic [7:0]       upper_chip_enable_ctrl,
    output logic [7:0]       write_protect_ctrl,
    output logic [7:0]       watchdog_control,
    output logic [7:0]       ethernet_buffer_size_cfg,
    output tap_pkg::address_mode_type address_mode,
    output logic             mem_addr_ok
);
    import tap_pkg::*;

    localparam int NREG = 12;
    localparam logic [7:0] ADDRS [NREG] = '{
        `ADDR_EXT_INTERRUPT_FLAGS, `ADDR_P4, `ADDR_ADDRESS_CONTROL, `ADDR_P5, `ADDR_CAN, `ADDR_P6,
        `ADDR_MEMORY_CHIP_ENABLE_CTRL, `ADDR_COR, `ADDR_UPPER_CHIP_ENABLE_CTRL, `ADDR_WRITE_PROTECT_CTRL, `ADDR_WATCHDOG_CONTROL, `ADDR_EBS};
    localparam logic [7:0] MASKS [NREG] = '{
        `MASK_EXT_INTERRUPT_FLAGS, `MASK_P4, `MASK_ADDRESS_CONTROL, `MASK_P5, `MASK_CAN, `MASK_P6,
        `MASK_MEMORY_CHIP_ENABLE_CTRL, `MASK_COR, `MASK_UPPER_CHIP_ENABLE_CTRL, `MASK_WRITE_PROTECT_CTRL, `MASK_WATCHDOG_CONTROL, `MASK_EBS};
    localparam logic [7:0] RSTS [NREG] = '{
        `RST_EXT_INTERRUPT_FLAGS, `RST_P4, `RST_ADDRESS_CONTROL, `RST_P5, `RST_CAN, `RST_P6,
        `RST_MEMORY_CHIP_ENABLE_CTRL, `RST_COR, `RST_UPPER_CHIP_ENABLE_CTRL, `RST_WRITE_PROTECT_CTRL, `RST_WATCHDOG_CONTROL, `RST_EBS};
    localparam logic [7:0] SPECIALS [NREG] = '{
        `SPECIAL_EXT_INTERRUPT_FLAGS, 8'h00, `SPECIAL_ADDRESS_CONTROL, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, `SPECIAL_WATCHDOG_CONTROL, 8'h00};

    logic [7:0]    regs [NREG];
    logic [7:0]    div_count;
    logic          cycle_tick;

    // Machine-cycle enable from the system clock
    always_ff @(posedge clk) begin
        if (reset) begin
            div_count <= 8'h00;
        end else if (div_count == 8'(CYCLE_DIV - 1)) begin
            div_count <= 8'h00;
        end else begin
            div_count <= div_count + 8'h01;
        end
    end
    assign cycle_tick = (div_count == 8'(CYCLE_DIV - 1));

    tap_window u_window (
        .clk         (clk),
        .reset       (reset),
        .cycle_tick  (cycle_tick),
        .wr_en       (wr_en),
        .wr_addr     (wr_addr),
        .wr_data     (wr_data),
        .state       (),
        .window_open (window_open)
    );

    function automatic logic [7:0] merge_write(input logic [7:0] old_val,
                                               input logic [7:0] new_val,
                                               input logic [7:0] mask,
                                               input logic       open);
        logic [7:0] keep;
        keep = open ? 8'h00 : mask;
        merge_write = (old_val & keep) | (new_val & ~keep);
    endfunction

    genvar gi;
    generate
        for (gi = 0; gi < NREG; gi++) begin : g_reg
            always_ff @(posedge clk) begin
                if (reset) begin
                    // Special bits keep value unless power-on reset
                    if (power_on_reset) begin
                        regs[gi] <= RSTS[gi];
                    end else begin
                        regs[gi] <= (regs[gi] & SPECIALS[gi]) |
                                    (RSTS[gi] & ~SPECIALS[gi]);
                    end
                    if (ADDRS[gi] == `ADDR_ADDRESS_CONTROL) begin
                        regs[gi][1:0] <= rom_enabled ? `MODE_CONTIG
                                                     : `MODE_16BIT;
                    end
                end else if (wr_en && wr_addr == ADDRS[gi]) begin
                    regs[gi] <= merge_write(regs[gi], wr_data, MASKS[gi],
                                            window_open);
                end
            end
        end
    endgenerate

    assign ext_interrupt_flags      = regs[0];
    assign port4_pin_config         = regs[1];
    assign address_control          = regs[2];
    assign port5_pin_config         = regs[3];
    assign can0_control             = regs[4];
    assign port6_pin_config         = regs[5];
    assign memory_chip_enable_ctrl  = regs[6];
    assign clock_output_config      = regs[7];
    assign upper_chip_enable_ctrl   = regs[8];
    assign write_protect_ctrl       = regs[9];
    assign watchdog_control         = regs[10];
    assign ethernet_buffer_size_cfg = regs[11];

    always_comb begin
        if (address_control[1]) begin
            address_mode = mode_contiguous;
        end else if (address_control[0]) begin
            address_mode = mode_paged;
        end else begin
            address_mode = mode_16bit;
        end
    end

    assign mem_addr_ok = (address_mode != mode_16bit) ||
                         (mem_addr <= `MEM_16BIT_LIMIT);

    // Registered read port; key register reads as its reset value
    always_ff @(posedge clk) begin
        if (reset) begin
            rd_data <= 8'h00;
            rd_hit  <= 1'b0;
        end else begin
            rd_data <= 8'h00;
            rd_hit  <= 1'b0;
            if (rd_en) begin
                if (rd_addr == `ADDR_KEY) begin
                    rd_data <= 8'hff;
                    rd_hit  <= 1'b1;
                end else begin
                    for (int i = 0; i < NREG; i++) begin
                        if (rd_addr == ADDRS[i]) begin
                            rd_data <= regs[i];
                            rd_hit  <= 1'b1;
                        end
                    end
                end
            end
        end
    end
endmodule

//--- dv/tap_checker_assertions.sv
// Port-level checker for the timed-access register bank
`timescale 1ns/10ps
module tap_checker (
    input  wire logic                clk,
    input  wire logic                reset,
    input  wire logic                rom_enabled,
    input  wire logic                wr_en,
    input  wire logic [7:0]          wr_addr,
    input  wire logic [7:0]          wr_data,
    input  wire logic                rd_en,
    input  wire logic [7:0]          rd_addr,
    input  wire logic [23:0]         mem_addr,
    input  wire logic [7:0]          rd_data,
    input  wire logic                window_open,
    input  wire logic [7:0]          port4_pin_config,
    input  wire logic [7:0]          address_control,
    input  tap_pkg::address_mode_type address_mode,
    input  wire logic                mem_addr_ok
);
    import tap_pkg::*;
    logic half;
    logic arm;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // First key byte seen, second pending
    always_ff @(posedge clk) begin
        if (reset) begin
            half <= 1'b0;
        end else if (wr_en) begin
            half <= wr_addr == 8'hc7 && wr_data == 8'haa;
        end
    end
    assign arm = half && wr_en && wr_addr == 8'hc7 && wr_data == 8'h55;
    AST_KEY_ARMS: assert property (arm |=> window_open)
        else $error("window not opened by key pair");
    AST_KEY_ONLY: assert property ($rose(window_open) |-> $past(arm))
        else $error("window opened without key pair");
    AST_WIN_CLOSES: assert property ($rose(window_open) |-> ##[1:16] !window_open)
        else $error("window stays open too long");
    AST_ONE_WRITE: assert property (
        window_open && wr_en && wr_addr != 8'hc7 |=> !window_open)
        else $error("window open after its one write");
    AST_P4_LOCKED: assert property (
        wr_en && !window_open && wr_addr == 8'h92 |=> $stable(port4_pin_config[5:0]))
        else $error("protected port bits changed while locked");
    AST_KEY_READ: assert property (rd_en && rd_addr == 8'hc7 |=> rd_data == 8'hff)
        else $error("key register read not ff");
    AST_MODE_DECODE: assert property (
        address_mode == (address_control[1] ? mode_contiguous
        : address_control[0] ? mode_paged : mode_16bit))
        else $error("address mode decode wrong");
    AST_MEM_LIMIT: assert property (
        mem_addr_ok == !(address_mode == mode_16bit && mem_addr > 24'h00ffff))
        else $error("memory limit check wrong");
    AST_MODE_RESET: assert property (
        $fell(reset) |-> address_control[1:0] == (rom_enabled ? 2'b10 : 2'b00))
        else $error("address mode reset default wrong");
endmodule
bind timed_access_protection tap_checker chk (
    .clk(clk), .reset(reset), .rom_enabled(rom_enabled), .wr_en(wr_en),
    .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr),
    .mem_addr(mem_addr), .rd_data(rd_data), .window_open(window_open),
    .port4_pin_config(port4_pin_config), .address_control(address_control),
    .address_mode(address_mode), .mem_addr_ok(mem_addr_ok)
);

//--- dv/timed_access_protection_test.sv
// Self-checking bench for the timed-access register bank
`timescale 1ns/10ps
`include "tap_cfg.svh"
module timed_access_protection_test;
    import tap_pkg::*;
    logic             clk = 1'b0;
    logic             reset = 1'b1;
    logic             power_on_reset = 1'b1;
    logic             rom_enabled = 1'b1;
    logic             wr_en = 1'b0;
    logic             rd_en = 1'b0;
    logic [7:0]       wr_addr = 8'h00;
    logic [7:0]       wr_data = 8'h00;
    logic [7:0]       rd_addr = 8'h00;
    logic [23:0]      mem_addr = 24'h010000;
    logic [7:0]       rd_data;
    logic [7:0]       got;
    logic [7:0]       outs [12];
    logic             rd_hit;
    logic             window_open;
    logic             mem_addr_ok;
    address_mode_type address_mode;
    int               err_count = 0;
    int               n_compared = 0;
    int               cycles = 0;
    logic [7:0] adr [12] = '{`ADDR_EXT_INTERRUPT_FLAGS, `ADDR_P4, `ADDR_ADDRESS_CONTROL, `ADDR_P5, `ADDR_CAN, `ADDR_P6,
        `ADDR_MEMORY_CHIP_ENABLE_CTRL, `ADDR_COR, `ADDR_UPPER_CHIP_ENABLE_CTRL, `ADDR_WRITE_PROTECT_CTRL, `ADDR_WATCHDOG_CONTROL, `ADDR_EBS};
    logic [7:0] msk [12] = '{`MASK_EXT_INTERRUPT_FLAGS, `MASK_P4, `MASK_ADDRESS_CONTROL, `MASK_P5, `MASK_CAN, `MASK_P6,
        `MASK_MEMORY_CHIP_ENABLE_CTRL, `MASK_COR, `MASK_UPPER_CHIP_ENABLE_CTRL, `MASK_WRITE_PROTECT_CTRL, `MASK_WATCHDOG_CONTROL, `MASK_EBS};
    logic [7:0] rst [12] = '{`RST_EXT_INTERRUPT_FLAGS, `RST_P4, `RST_ADDRESS_CONTROL | 8'h02, `RST_P5, `RST_CAN, `RST_P6,
        `RST_MEMORY_CHIP_ENABLE_CTRL, `RST_COR, `RST_UPPER_CHIP_ENABLE_CTRL, `RST_WRITE_PROTECT_CTRL, `RST_WATCHDOG_CONTROL, `RST_EBS};

    timed_access_protection #(.CYCLE_DIV(4)) dut (
        .clk(clk), .reset(reset), .power_on_reset(power_on_reset),
        .rom_enabled(rom_enabled), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
        .rd_en(rd_en), .rd_addr(rd_addr), .mem_addr(mem_addr), .rd_data(rd_data),
        .rd_hit(rd_hit), .window_open(window_open), .ext_interrupt_flags(outs[0]),
        .port4_pin_config(outs[1]), .address_control(outs[2]), .port5_pin_config(outs[3]),
        .can0_control(outs[4]), .port6_pin_config(outs[5]),
        .memory_chip_enable_ctrl(outs[6]), .clock_output_config(outs[7]),
        .upper_chip_enable_ctrl(outs[8]), .write_protect_ctrl(outs[9]),
        .watchdog_control(outs[10]), .ethernet_buffer_size_cfg(outs[11]),
        .address_mode(address_mode), .mem_addr_ok(mem_addr_ok)
    );

    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count = err_count + 1;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        wr_addr <= a;
        wr_data <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        rd_en <= 1'b1;
        rd_addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 got = rd_data;
    endtask
    task automatic unlock();
        wr(`ADDR_KEY, `KEY_FIRST);
        wr(`ADDR_KEY, `KEY_SECOND);
    endtask
    task automatic tally_and_finish();
        $display("Compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        for (int i = 0; i < 12; i++) begin
            rd(adr[i]);
            chk(got, rst[i]);
            chk({7'h0, rd_hit}, 8'h01);
            chk(outs[i], rst[i]);
        end
        rd(`ADDR_KEY);
        chk(got, 8'hff);
        rd(8'h00);
        chk({7'h0, rd_hit}, 8'h00);
        // Locked write, one unlocked write, then locked again
        for (int i = 0; i < 12; i++) begin
            wr(adr[i], 8'hff);
            rd(adr[i]);
            chk(got, rst[i] | ~msk[i]);
            unlock();
            wr(adr[i], 8'h00);
            rd(adr[i]);
            chk(got, 8'h00);
            wr(adr[i], 8'hff);
            rd(adr[i]);
            chk(got, ~msk[i]);
            chk(outs[i], ~msk[i]);
        end
        // Broken key sequence leaves port 4 locked
        wr(`ADDR_KEY, `KEY_FIRST);
        wr(`ADDR_P5, 8'h00);
        wr(`ADDR_KEY, `KEY_SECOND);
        wr(`ADDR_P4, 8'h3f);
        rd(`ADDR_P4);
        chk(got, 8'h00);
        // Window expires before the write
        unlock();
        #1 chk({7'h0, window_open}, 8'h01);
        repeat (20) @(posedge clk);
        #1 chk({7'h0, window_open}, 8'h00);
        wr(`ADDR_P4, 8'h3f);
        rd(`ADDR_P4);
        chk(got, 8'h00);
        for (int m = 3; m >= 0; m--) begin
            unlock();
            wr(`ADDR_ADDRESS_CONTROL, 8'h08 | 8'(m));
            #1 chk({6'h0, address_mode}, m > 1 ? 8'h02 : 8'(m));
            chk({7'h0, mem_addr_ok}, m > 0 ? 8'h01 : 8'h00);
        end
        @(posedge clk);
        mem_addr <= 24'h00ffff;
        @(posedge clk);
        #1 chk({7'h0, mem_addr_ok}, 8'h01);
        // Warm reset with ROM off keeps special bit
        @(posedge clk);
        reset <= 1'b1;
        power_on_reset <= 1'b0;
        rom_enabled <= 1'b0;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        rd(`ADDR_ADDRESS_CONTROL);
        chk(got, `RST_ADDRESS_CONTROL | `SPECIAL_ADDRESS_CONTROL);
        tally_and_finish();
    end
endmodule
